/* File: hdl/cc5_channel_regs.sv */
// Purpose: Channel five configuration and calibration register group.
// Assumes: Avalon-MM slave, one clock, async active-low reset.
// Notes: Every access takes exactly one wait state.
//
// Operation
// - Config bits 15:6 hold a ten-bit signed phase delay in modulator clocks.
// - Config bits 5:3 are read-only and always read zero.
// - Config bit 2 set disables this channel's DC filter, clear leaves it global.
// - Config bits 1:0 pick normal, shorted, positive test or negative test input.
// - The config register sits at index 22h and resets to 0000h.
// - Offset calibration is 24-bit signed with bits 23:8 in the offset high word.
// - Offset bits 7:0 sit in bits 15:8 of the offset low register.
// - Gain calibration is 24-bit unsigned with bits 23:8 in the gain high word.
// - Gain bits 7:0 sit in bits 15:8 of the gain low register.
// - The gain high word sits at index 25h and resets to 8000h for unity gain.
// - The low byte of each calibration low register is read-only zero.
// - Offset high at 23h, offset low at 24h and gain low at 26h reset to zero.
// - The channel disable acts only when set, else the global field rules.
`timescale 1ns/1ps
`default_nettype none
module cc5_channel_regs #(
    parameter int PHASE_W = 10,
    parameter int CAL_W = 24
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [cc5_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [cc5_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [cc5_pkg::BE_W-1:0] avs_byteenable,
    output logic [cc5_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [cc5_pkg::DC_FIELD_W-1:0] global_dc_filter_field,
    output logic signed [PHASE_W-1:0] phase_delay_field,
    output logic dc_filter_disable_bit,
    output cc5_pkg::cc5_input_sel_t input_select_field,
    output logic [3:0] input_path_onehot,
    output logic [cc5_pkg::DC_FIELD_W-1:0] dc_filter_setting,
    output logic dc_filter_active,
    output logic signed [CAL_W-1:0] offset_cal_value,
    output logic [CAL_W-1:0] gain_cal_value
);
    import cc5_pkg::*;

    // Number of calibration pairs: offset first, gain second
    localparam int NUM_CAL = 2;
    localparam int CAL_OFFSET = 0;
    localparam int CAL_GAIN = 1;

    // True when a byte address lands on the given word index
    function automatic logic addr_hits(
        input logic [ADDR_W-1:0] addr,
        input logic [5:0] idx
    );
        addr_hits = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    // Select code to one-hot input path
    function automatic logic [3:0] path_decode(input cc5_input_sel_t sel);
        logic [3:0] hot;
        hot = 4'h0;
        unique case (sel)
            SEL_NORMAL: begin
                hot[PATH_NORMAL] = 1'b1;
            end
            SEL_SHORTED: begin
                hot[PATH_SHORTED] = 1'b1;
            end
            SEL_TEST_POS: begin
                hot[PATH_TEST_POS] = 1'b1;
            end
            SEL_TEST_NEG: begin
                hot[PATH_TEST_NEG] = 1'b1;
            end
        endcase
        path_decode = hot;
    endfunction

    // Bus handshake state
    logic req;
    logic ack;
    logic commit;

    // Address decode
    logic sel_cfg;
    logic sel_offset_high;
    logic sel_offset_low;
    logic sel_gain_high;
    logic sel_gain_low;

    // Configuration register storage (reserved bits are not stored)
    logic [PHASE_W-1:0] phase_reg;
    logic dc_dis_reg;
    cc5_input_sel_t sel_reg;
    logic [REG_W-1:0] cfg_rd;

    // Calibration pair wiring
    logic cal_wr_high [NUM_CAL];
    logic cal_wr_low [NUM_CAL];
    logic [REG_W-1:0] cal_high_rd [NUM_CAL];
    logic [REG_W-1:0] cal_low_rd [NUM_CAL];
    logic [CAL_W-1:0] cal_value [NUM_CAL];

    // Read return
    logic [DATA_W-1:0] next_readdata;

    // Request is held by the master until it sees waitrequest low
    assign req = avs_read | avs_write;

    // One wait state: high in the first cycle of every request
    assign avs_waitrequest = req & ~ack;

    // Acknowledge toggles so back-to-back requests each wait once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    // A write lands on the edge where waitrequest is seen low
    assign commit = avs_write & ack;

    // Register selection by word index
    assign sel_cfg = addr_hits(avs_address, CFG_IDX);
    assign sel_offset_high = addr_hits(avs_address, OFFSET_HIGH_IDX);
    assign sel_offset_low = addr_hits(avs_address, OFFSET_LOW_IDX);
    assign sel_gain_high = addr_hits(avs_address, GAIN_HIGH_IDX);
    assign sel_gain_low = addr_hits(avs_address, GAIN_LOW_IDX);

    // Phase delay field, split over two byte lanes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phase_reg <= CFG_RESET[PHASE_MSB:PHASE_LSB];
        end else if (commit && sel_cfg) begin
            if (avs_byteenable[1]) begin
                phase_reg[PHASE_W-1:2] <= avs_writedata[PHASE_MSB:8];
            end
            if (avs_byteenable[0]) begin
                phase_reg[1:0] <= avs_writedata[7:PHASE_LSB];
            end
        end
    end

    // Per-channel DC filter disable bit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dc_dis_reg <= CFG_RESET[DC_DIS_POS];
        end else if (commit && sel_cfg && avs_byteenable[0]) begin
            dc_dis_reg <= avs_writedata[DC_DIS_POS];
        end
    end

    // Input selection field; bits 5:3 of the write are dropped
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_reg <= cc5_input_sel_t'(CFG_RESET[SEL_MSB:SEL_LSB]);
        end else if (commit && sel_cfg && avs_byteenable[0]) begin
            sel_reg <= cc5_input_sel_t'(avs_writedata[SEL_MSB:SEL_LSB]);
        end
    end

    // Configuration read view with reserved bits forced low
    always_comb begin
        cfg_rd = '0;
        cfg_rd[PHASE_MSB:PHASE_LSB] = phase_reg;
        cfg_rd[CFG_RSVD_MSB:CFG_RSVD_LSB] = 3'b000;
        cfg_rd[DC_DIS_POS] = dc_dis_reg;
        cfg_rd[SEL_MSB:SEL_LSB] = sel_reg;
    end

    // Write strobes for the calibration pairs
    assign cal_wr_high[CAL_OFFSET] = commit & sel_offset_high;
    assign cal_wr_low[CAL_OFFSET] = commit & sel_offset_low;
    assign cal_wr_high[CAL_GAIN] = commit & sel_gain_high;
    assign cal_wr_low[CAL_GAIN] = commit & sel_gain_low;

    // Offset and gain calibration storage
    for (genvar i = 0; i < NUM_CAL; i++) begin : g_cal
        localparam logic [15:0] HI_RST =
            (i == CAL_GAIN) ? GAIN_HIGH_RESET : OFFSET_HIGH_RESET;
        localparam logic [15:0] LO_RST =
            (i == CAL_GAIN) ? GAIN_LOW_RESET : OFFSET_LOW_RESET;
        cc5_cal_pair #(
            .HIGH_RESET(HI_RST),
            .LOW_RESET(LO_RST)
        ) u_pair (
            .mclk(mclk),
            .rst_n(rst_n),
            .wr_high(cal_wr_high[i]),
            .wr_low(cal_wr_low[i]),
            .byte_en(avs_byteenable[1:0]),
            .wdata(avs_writedata[REG_W-1:0]),
            .high_rd(cal_high_rd[i]),
            .low_rd(cal_low_rd[i]),
            .value(cal_value[i])
        );
    end

    // Read multiplexer; unmapped addresses and upper lanes read zero
    always_comb begin
        next_readdata = '0;
        if (sel_cfg) begin
            next_readdata[REG_W-1:0] = cfg_rd;
        end else if (sel_offset_high) begin
            next_readdata[REG_W-1:0] = cal_high_rd[CAL_OFFSET];
        end else if (sel_offset_low) begin
            next_readdata[REG_W-1:0] = cal_low_rd[CAL_OFFSET];
        end else if (sel_gain_high) begin
            next_readdata[REG_W-1:0] = cal_high_rd[CAL_GAIN];
        end else if (sel_gain_low) begin
            next_readdata[REG_W-1:0] = cal_low_rd[CAL_GAIN];
        end
    end

    // Read data captured in the wait cycle, held until the next read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack) begin
            avs_readdata <= next_readdata;
        end
    end

    // Configuration fields straight from storage
    assign phase_delay_field = $signed(phase_reg);
    assign dc_filter_disable_bit = dc_dis_reg;
    assign input_select_field = sel_reg;

    // Registered one-hot input path for the analog front end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            input_path_onehot <= path_decode(cc5_input_sel_t'(CFG_RESET[1:0]));
        end else begin
            input_path_onehot <= path_decode(sel_reg);
        end
    end

    // Effective DC filter setting: local disable overrides global field
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dc_filter_setting <= DC_FIELD_OFF;
            dc_filter_active <= 1'b0;
        end else if (dc_dis_reg) begin
            dc_filter_setting <= DC_FIELD_OFF;
            dc_filter_active <= 1'b0;
        end else begin
            dc_filter_setting <= global_dc_filter_field;
            dc_filter_active <= (global_dc_filter_field != DC_FIELD_OFF);
        end
    end

    // Assembled calibration words
    assign offset_cal_value = $signed(cal_value[CAL_OFFSET]);
    assign gain_cal_value = cal_value[CAL_GAIN];

endmodule
`default_nettype wire

/* File: hdl/cc5_pkg.sv */
// Purpose: Shared constants and types for the channel five register group.
// Assumes: Avalon-MM slave with 32-bit data and a byte address bus.
// Notes: Printed register offsets are word indices; byte address is 4x.
package cc5_pkg;

    // Avalon bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int REG_W = 16;

    // Register word indices
    localparam logic [5:0] CFG_IDX = 6'h22;
    localparam logic [5:0] OFFSET_HIGH_IDX = 6'h23;
    localparam logic [5:0] OFFSET_LOW_IDX = 6'h24;
    localparam logic [5:0] GAIN_HIGH_IDX = 6'h25;
    localparam logic [5:0] GAIN_LOW_IDX = 6'h26;

    // Values after reset
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] OFFSET_HIGH_RESET = 16'h0000;
    localparam logic [15:0] OFFSET_LOW_RESET = 16'h0000;
    localparam logic [15:0] GAIN_HIGH_RESET = 16'h8000;
    localparam logic [15:0] GAIN_LOW_RESET = 16'h0000;

    // Configuration register field positions
    localparam int PHASE_MSB = 15;
    localparam int PHASE_LSB = 6;
    localparam int CFG_RSVD_MSB = 5;
    localparam int CFG_RSVD_LSB = 3;
    localparam int DC_DIS_POS = 2;
    localparam int SEL_MSB = 1;
    localparam int SEL_LSB = 0;

    // Calibration low register: data byte sits in the upper half
    localparam int CAL_LOW_LSB = 8;
    localparam int CAL_LOW_W = 8;

    // Global DC filter field width and its off code
    localparam int DC_FIELD_W = 4;
    localparam logic [3:0] DC_FIELD_OFF = 4'h0;

    // Channel input selection codes
    typedef enum logic [1:0] {
        SEL_NORMAL = 2'b00,
        SEL_SHORTED = 2'b01,
        SEL_TEST_POS = 2'b10,
        SEL_TEST_NEG = 2'b11
    } cc5_input_sel_t;

    // One-hot input path positions
    localparam int PATH_NORMAL = 0;
    localparam int PATH_SHORTED = 1;
    localparam int PATH_TEST_POS = 2;
    localparam int PATH_TEST_NEG = 3;

endpackage

/* File: hdl/cc5_cal_pair.sv */
// Purpose: One calibration word split over a high and a low register.
// Assumes: Write strobes arrive already decoded and qualified by the bus.
// Notes: Low register keeps only its upper byte; the lower byte is absent.
`timescale 1ns/1ps
`default_nettype none
module cc5_cal_pair #(
    parameter logic [15:0] HIGH_RESET = 16'h0000,
    parameter logic [15:0] LOW_RESET = 16'h0000
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wr_high,
    input wire logic wr_low,
    input wire logic [1:0] byte_en,
    input wire logic [15:0] wdata,
    output logic [15:0] high_rd,
    output logic [15:0] low_rd,
    output logic [23:0] value
);
    import cc5_pkg::*;

    logic [15:0] high_word;
    logic [7:0] low_byte;

    // High word, writable byte by byte
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            high_word <= HIGH_RESET;
        end else if (wr_high) begin
            if (byte_en[0]) begin
                high_word[7:0] <= wdata[7:0];
            end
            if (byte_en[1]) begin
                high_word[15:8] <= wdata[15:8];
            end
        end
    end

    // Low byte from bits 15:8; bits 7:0 are not stored
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            low_byte <= LOW_RESET[15:8];
        end else if (wr_low && byte_en[1]) begin
            low_byte <= wdata[15:8];
        end
    end

    // Read views and the assembled 24-bit word
    assign high_rd = high_word;
    assign low_rd = {low_byte, 8'h00};
    assign value = {high_word, low_byte};

endmodule
`default_nettype wire

/* File: bench/cc5_channel_regs_props.sv */
// Purpose: Port checks on the channel five register group.
// Assumes: One wait state per access; byte address is 4x index.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module cc5_channel_regs_props #(
    parameter int PHASE_W = 10,
    parameter int CAL_W = 24
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [cc5_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [cc5_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [cc5_pkg::BE_W-1:0] avs_byteenable,
    input wire logic [cc5_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [cc5_pkg::DC_FIELD_W-1:0] global_dc_filter_field,
    input wire logic signed [PHASE_W-1:0] phase_delay_field,
    input wire logic dc_filter_disable_bit,
    input wire cc5_pkg::cc5_input_sel_t input_select_field,
    input wire logic [3:0] input_path_onehot,
    input wire logic [cc5_pkg::DC_FIELD_W-1:0] dc_filter_setting,
    input wire logic dc_filter_active,
    input wire logic signed [CAL_W-1:0] offset_cal_value,
    input wire logic [CAL_W-1:0] gain_cal_value
);
    import cc5_pkg::*;
    logic [15:0] wd_q;
    logic [1:0] sel_q;
    logic [3:0] set_q;
    logic act_q;
    // Last write data and one-cycle-late filter inputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wd_q <= 16'h0000;
            sel_q <= 2'b00;
            set_q <= 4'h0;
            act_q <= 1'b0;
        end else begin
            wd_q <= avs_writedata[15:0];
            sel_q <= input_select_field;
            set_q <= dc_filter_disable_bit ? 4'h0 : global_dc_filter_field;
            act_q <= !dc_filter_disable_bit && global_dc_filter_field != 4'h0;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // Accepted full-word write and completed read
    sequence wr_at(a);
        avs_write && !avs_waitrequest && avs_address == a
            && avs_byteenable[1:0] == 2'b11;
    endsequence
    sequence rd_at(a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("access took over one wait");
    chk_cfg_rsvd: assert property (rd_at(8'h88) |->
        avs_readdata[5:3] == 3'b000) else $error("config reserved bits set");
    chk_cal_rsvd: assert property (rd_at(8'h90) or rd_at(8'h98) |->
        avs_readdata[7:0] == 8'h00) else $error("cal low byte not zero");
    chk_phase_wr: assert property (wr_at(8'h88) |=>
        phase_delay_field == wd_q[15:6]) else $error("phase not written");
    chk_cfg_wr: assert property (wr_at(8'h88) |=>
        dc_filter_disable_bit == wd_q[2] && input_select_field == wd_q[1:0])
        else $error("config fields not written");
    chk_onehot_sel: assert property (input_path_onehot == 4'b0001 << sel_q)
        else $error("input path not one-hot of select");
    chk_dc_follow: assert property (dc_filter_setting == set_q
        && dc_filter_active == act_q) else $error("dc filter state wrong");
    chk_gain_low: assert property (wr_at(8'h98) |=>
        gain_cal_value[7:0] == wd_q[15:8]) else $error("gain low wrong");
    chk_off_high: assert property (wr_at(8'h8c) |=>
        offset_cal_value[23:8] == wd_q) else $error("offset high wrong");
endmodule
`default_nettype wire

/* File: bench/cc5_channel_regs_bench.sv */
// Purpose: Self-checking bench for the channel five register group.
// Assumes: One wait state per access.
// Notes: Rows hold address, write data, readback and reset value.
`timescale 1ns/1ps
`default_nettype none
module cc5_channel_regs_bench;
    import cc5_pkg::*;
    logic mclk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] avs_byteenable, global_dc_filter_field, input_path_onehot;
    logic [3:0] dc_filter_setting;
    logic dc_filter_disable_bit, dc_filter_active;
    logic signed [9:0] phase_delay_field;
    cc5_input_sel_t input_select_field;
    logic signed [23:0] offset_cal_value;
    logic [23:0] gain_cal_value;
    int errors, check_count;
    logic [7:0] ra [6] = '{8'h88, 8'h8c, 8'h90, 8'h94, 8'h98, 8'h40};
    logic [15:0] rw [6] = '{16'hffff, 16'ha5c3, 16'hffff, 16'h1234,
        16'h00ff, 16'hffff};
    logic [15:0] rb [6] = '{16'hffc7, 16'ha5c3, 16'hff00, 16'h1234,
        16'h0000, 16'h0000};
    logic [15:0] rs [6] = '{16'h0000, 16'h0000, 16'h0000, 16'h8000,
        16'h0000, 16'h0000};
    cc5_channel_regs #(.PHASE_W(10), .CAL_W(24)) DUT (.mclk, .rst_n,
        .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .global_dc_filter_field, .phase_delay_field, .dc_filter_disable_bit,
        .input_select_field, .input_path_onehot, .dc_filter_setting,
        .dc_filter_active, .offset_cal_value, .gain_cal_value);
    task automatic results();
        $display("checks=%0d errors=%0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus access, held until waitrequest is seen low
    task automatic xfer(input logic [7:0] a, input logic w,
            input logic [15:0] d, input logic [3:0] be);
        int n;
        n = 0;
        if (mclk !== 1'b1) @(posedge mclk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        do begin
            @(negedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            errors++;
            results();
        end
        q = avs_readdata;
        @(posedge mclk);
    endtask
    // Release the bus and let lagged outputs settle
    task automatic idle();
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
    endtask
    task automatic rd_resets();
        foreach (ra[i]) begin
            xfer(ra[i], 1'b0, 16'h0000, 4'hf);
            chk(q, {16'h0000, rs[i]});
        end
        idle();
    endtask
    // Free-running 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        global_dc_filter_field = 4'h5;
        do_reset();
        chk({8'h00, gain_cal_value}, 32'h00800000);
        rd_resets();
        $display("reset test done");
        foreach (ra[i]) xfer(ra[i], 1'b1, rw[i], 4'hf);
        foreach (ra[i]) begin
            xfer(ra[i], 1'b0, 16'h0000, 4'hf);
            chk(q, {16'h0000, rb[i]});
        end
        idle();
        chk({8'h00, offset_cal_value}, 32'h00a5c3ff);
        chk({8'h00, gain_cal_value}, 32'h00123400);
        chk({22'h0, phase_delay_field}, 32'h3ff);
        $display("row test done");
        // Lane 0 alone must not touch the calibration byte
        xfer(8'h90, 1'b1, 16'h1100, 4'h1);
        xfer(8'h90, 1'b0, 16'h0000, 4'h0);
        chk(q, 32'h0000ff00);
        idle();
        $display("byte lane test done");
        for (int i = 0; i < 4; i++) begin
            xfer(8'h88, 1'b1, {10'h200, 3'b111, i[0], i[1:0]}, 4'h3);
            idle();
            chk(32'(input_select_field), i);
            chk({28'h0, input_path_onehot}, 32'h1 << i);
            chk({31'h0, dc_filter_disable_bit}, i % 2);
            chk({28'h0, dc_filter_setting}, i[0] ? 0 : 5);
            chk({31'h0, dc_filter_active}, !i[0]);
            chk({22'h0, phase_delay_field}, 32'h200);
        end
        xfer(8'h88, 1'b0, 16'h0000, 4'hf);
        chk(q, 32'h00008007);
        idle();
        $display("select test done");
        @(posedge mclk);
        do_reset();
        rd_resets();
        $display("second reset test done");
        results();
    end
endmodule
bind cc5_channel_regs cc5_channel_regs_props #(.PHASE_W(PHASE_W),
    .CAL_W(CAL_W)) u_props (.mclk, .rst_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .global_dc_filter_field, .phase_delay_field, .dc_filter_disable_bit,
    .input_select_field, .input_path_onehot, .dc_filter_setting,
    .dc_filter_active, .offset_cal_value, .gain_cal_value);
`default_nettype wire
